// [include/ddm_link_if.sv]
// Pin-level link between the loading controller and the modulator core
`timescale 1ns/10ps
interface ddm_link_if;
	logic        wr_n;
	logic        cs_n;
	logic [15:0] data_bus;
	logic        serial_clk;
	logic        serial_in_line;
	logic        load;
	logic [3:0]  transfer_control_inputs;
	logic        freq_select_input;
	logic        sleep_pin;
	logic        reset_pin;
	modport device (input wr_n, cs_n, data_bus, serial_clk, serial_in_line, load,
		transfer_control_inputs, freq_select_input, sleep_pin, reset_pin);
	modport host (output wr_n, cs_n, data_bus, serial_clk, serial_in_line, load,
		transfer_control_inputs, freq_select_input, sleep_pin, reset_pin);
endinterface : ddm_link_if

// [include/ddm_pkg.sv]
// Shared constants for the modulator core and its loading controller
package ddm_pkg;
	localparam int CLK_PERIOD_NS     = 5;
	localparam int HOST_PHASE_NS     = 20;
	localparam int HOST_PHASE_CYCLES = (HOST_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACC_W             = 32;
	localparam int PHASE_W           = 12;
	localparam int IQ_W              = 20;
	localparam int AMP_W             = 10;
	localparam int DATA_W            = 16;
	localparam int TC_W              = 4;
	localparam int CR_W              = 4;
	localparam int SYNC_STAGES       = 4;
	localparam int CTRL_W            = 6;
	localparam int SHIFT_NARROW      = 8;
	localparam int SHIFT_WIDE        = 16;
	localparam int CR_BUS_WIDTH      = 0;
	localparam int CR_SLEEP          = 1;
	localparam int CR_AM             = 2;
	localparam int CR_BYPASS         = 3;
	localparam int TC_SOURCE_BIT     = 2;
	localparam int Q_LSB             = 10;
	localparam int PROD_LSB          = 9;
	localparam int SINE_LSB          = 11;
	localparam int SER_BITS          = 32;
	localparam logic [1:0]  TC_TOP_COMMAND = 2'h0;
	localparam logic [1:0]  DEST_FREQ_A    = 2'h0;
	localparam logic [1:0]  DEST_FREQ_B    = 2'h1;
	localparam logic [1:0]  DEST_PHASE     = 2'h2;
	localparam logic [1:0]  DEST_IQ        = 2'h3;
	localparam logic [11:0] SINE_SPAN      = 12'h800;
	localparam logic [11:0] SINE_QUARTER   = 12'h400;
	localparam logic [9:0]  SINE_MAX       = 10'h1FF;
	localparam logic [7:0]  ADDR_PAR       = 8'h00;
	localparam logic [7:0]  ADDR_SER       = 8'h04;
	localparam logic [7:0]  ADDR_LOAD      = 8'h08;
	localparam logic [7:0]  ADDR_PINS      = 8'h0C;
	localparam logic [7:0]  ADDR_STATUS    = 8'h10;
	localparam int PIN_FSEL  = 0;
	localparam int PIN_SLEEP = 1;
	localparam int PIN_RESET = 2;
endpackage : ddm_pkg

// [tb/ddm_link_monitor.sv]
// Concurrent checks on the link between the loading controller and the modulator core
`timescale 1ns/10ps
module ddm_link_monitor
	import ddm_pkg::*;
(
	input wire logic       clock_in,
	input wire logic       nrst_in,
	input wire logic       wr_n,
	input wire logic       cs_n,
	input wire logic       serial_clk,
	input wire logic       load,
	input wire logic [3:0] transfer_control_inputs,
	input wire logic       reset_pin,
	input wire logic       sleep_pin,
	input wire logic [9:0] dac_code_out,
	input wire logic       sleep_out,
	input wire logic [3:0] mode_control_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!nrst_in);
	wr_cs_pair_a: assert property (wr_n == cs_n)
		else $error("write strobe and select differ");
	wr_pulse_len_a: assert property ($fell(wr_n) |-> !wr_n [*4] ##1 wr_n)
		else $error("write strobe width wrong");
	tc_hold_a: assert property (load |-> $stable(transfer_control_inputs))
		else $error("transfer code moved during load");
	load_len_a: assert property ($rose(load) |-> load [*4] ##1 !load)
		else $error("load pulse width wrong");
	sclk_high_a: assert property ($rose(serial_clk) |-> serial_clk [*4] ##1 !serial_clk)
		else $error("serial clock high time wrong");
	pin_clear_a: assert property (reset_pin [*5] |=> mode_control_out == 4'h0)
		else $error("reset pin left command register set");
	sleep_flag_a: assert property (sleep_out ==
		(mode_control_out[CR_SLEEP] || $past(sleep_pin, 2)))
		else $error("sleep flag disagrees with sleep bit and pin");
	sleep_dac_a: assert property (sleep_out [*6] |-> dac_code_out == 10'h000)
		else $error("converter code not zero in sleep");
	cmd_source_a: assert property ($changed(mode_control_out) |->
		transfer_control_inputs[3:2] == 2'b00 || $past(reset_pin, 2)
		|| $past(reset_pin, 3) || $past(reset_pin, 4))
		else $error("command register changed without command load");
endmodule : ddm_link_monitor

// [tb/dds_modulator_core_test.sv]
// Self-checking bench: controller drives the core across the link
`timescale 1ns/10ps
module dds_modulator_core_test
	import ddm_pkg::*;
;
	logic        clock_in;
	logic        nrst_in;
	logic [7:0]  addr_in;
	logic [31:0] wdata_in;
	logic        wr_in;
	logic        rd_in;
	logic [31:0] rdata_out;
	logic        busy_out;
	logic [9:0]  dac_code_out;
	logic        sleep_out;
	logic [3:0]  mode_control_out;
	logic [9:0]  dseq [6];
	int          n_mismatch;
	int          tests_run;
	int          cycles;
	int          n1;
	int          n2;

	ddm_link_if link();
	ddm_core i_ddm_core (.clock_in(clock_in), .nrst_in(nrst_in), .link(link),
		.dac_code_out(dac_code_out), .sleep_out(sleep_out),
		.mode_control_out(mode_control_out));
	ddm_host i_ddm_host (.clock_in(clock_in), .nrst_in(nrst_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.busy_out(busy_out), .link(link));
	ddm_link_monitor i_ddm_link_monitor (.clock_in(clock_in), .nrst_in(nrst_in),
		.wr_n(link.wr_n), .cs_n(link.cs_n), .serial_clk(link.serial_clk),
		.load(link.load), .transfer_control_inputs(link.transfer_control_inputs),
		.reset_pin(link.reset_pin), .sleep_pin(link.sleep_pin), .dac_code_out(dac_code_out),
		.sleep_out(sleep_out), .mode_control_out(mode_control_out));

	initial begin
		clock_in = 1'b0;
		forever #2.5 clock_in = ~clock_in;
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic strobe(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
	endtask : strobe

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		strobe(a, d);
		#1;
		n = 0;
		while (busy_out !== 1'b0 && n < 400) begin
			@(posedge clock_in);
			#1;
			n++;
		end
	endtask : wr

	// Generous settle covers the synchronised load path plus the output pipeline
	task automatic ld(input logic [3:0] tc);
		wr(ADDR_LOAD, {28'h0, tc});
		repeat (16) @(posedge clock_in);
		#1;
	endtask : ld

	task automatic cmd(input logic [3:0] v);
		wr(ADDR_PAR, {28'h0, v});
		ld(4'h0);
	endtask : cmd

	task automatic grab();
		for (int i = 0; i < 6; i++) begin
			@(posedge clock_in);
			#1;
			dseq[i] = dac_code_out;
		end
	endtask : grab

	task automatic lat(input logic [3:0] v, output int n);
		logic [3:0] old;
		old = mode_control_out;
		wr(ADDR_PAR, {28'h0, v});
		strobe(ADDR_LOAD, 32'h0);
		n = 0;
		while (link.load !== 1'b1 && n < 50) begin
			@(posedge clock_in);
			n++;
		end
		n = 0;
		while (mode_control_out === old && n < 50) begin
			@(posedge clock_in);
			n++;
		end
		repeat (16) @(posedge clock_in);
		#1;
	endtask : lat

	task automatic t_reset();
		@(posedge clock_in);
		addr_in <= ADDR_STATUS;
		rd_in <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
		#1;
		chk("status", rdata_out, 32'h0000_0000);
		chk("mode", {28'h0, mode_control_out}, 32'h0000_0000);
		chk("sleep", {31'h0, sleep_out}, 32'h0000_0000);
		$display("reset state done");
	endtask : t_reset

	task automatic t_narrow();
		wr(ADDR_PAR, 32'h0000_FF04);
		wr(ADDR_PAR, 32'h0000_EE00);
		ld(4'hA);
		chk("dac narrow", {22'h0, dac_code_out}, 32'h0000_01FF);
		$display("narrow bus done");
	endtask : t_narrow

	task automatic t_command();
		cmd(4'h1);
		chk("mode", {28'h0, mode_control_out}, 32'h0000_0001);
		wr(ADDR_SER, 32'h0000_000E);
		ld(4'h1);
		chk("mode serial", {28'h0, mode_control_out}, 32'h0000_0001);
		wr(ADDR_PAR, 32'h0000_0000);
		wr(ADDR_PAR, 32'h0000_0C00);
		ld(4'hA);
		chk("dac wide", {22'h0, dac_code_out}, 32'h0000_0201);
		$display("command and wide bus done");
	endtask : t_command

	task automatic t_am();
		wr(ADDR_PAR, 32'h0000_0000);
		wr(ADDR_PAR, 32'h0000_0400);
		ld(4'hA);
		cmd(4'h5);
		wr(ADDR_PAR, 32'h0000_0007);
		wr(ADDR_PAR, 32'h0000_FC00);
		ld(4'hB);
		chk("dac q", {22'h0, dac_code_out}, 32'h0000_01FE);
		wr(ADDR_PAR, 32'h0000_0000);
		wr(ADDR_PAR, 32'h0000_01FF);
		ld(4'hB);
		chk("dac i", {22'h0, dac_code_out}, 32'h0000_0000);
		// Eighth-turn phase with full I and Q: the sum must roll over, not clip
		wr(ADDR_PAR, 32'h0000_0000);
		wr(ADDR_PAR, 32'h0000_0200);
		ld(4'hA);
		wr(ADDR_PAR, 32'h0000_0007);
		wr(ADDR_PAR, 32'h0000_FDFF);
		ld(4'hB);
		chk("dac wrap", {22'h0, dac_code_out}, 32'h0000_02FE);
		wr(ADDR_PAR, 32'h0000_0000);
		wr(ADDR_PAR, 32'h0000_0400);
		ld(4'hA);
		$display("amplitude done");
	endtask : t_am

	task automatic t_sync();
		lat(4'h9, n1);
		lat(4'hD, n2);
		chk("latency gap", n1 - n2, 32'h0000_0004);
		chk("mode", {28'h0, mode_control_out}, 32'h0000_000D);
		cmd(4'h1);
		$display("synchroniser done");
	endtask : t_sync

	task automatic t_freq();
		wr(ADDR_SER, 32'h8000_0000);
		ld(4'hC);
		grab();
		chk("dac peak", dseq[0] == 10'h1FF || dseq[0] == 10'h201, 32'h1);
		for (int i = 0; i < 5; i++) chk("half turn", {22'h0, dseq[i] + dseq[i + 1]}, 0);
		wr(ADDR_PINS, 32'h0000_0001);
		repeat (16) @(posedge clock_in);
		grab();
		chk("dac held", dseq[0] == 10'h1FF || dseq[0] == 10'h201, 32'h1);
		for (int i = 0; i < 5; i++) chk("held", {22'h0, dseq[i + 1]}, {22'h0, dseq[0]});
		wr(ADDR_PINS, 32'h0000_0000);
		$display("frequency done");
	endtask : t_freq

	task automatic t_sleep();
		wr(ADDR_PINS, 32'h0000_0002);
		repeat (4) @(posedge clock_in);
		#1;
		chk("sleep pin", {31'h0, sleep_out}, 32'h1);
		chk("dac sleep pin", {22'h0, dac_code_out}, 32'h0000_0000);
		wr(ADDR_PINS, 32'h0000_0000);
		cmd(4'h3);
		chk("sleep", {31'h0, sleep_out}, 32'h1);
		chk("dac sleep", {22'h0, dac_code_out}, 32'h0000_0000);
		wr(ADDR_PINS, 32'h0000_0004);
		repeat (8) @(posedge clock_in);
		wr(ADDR_PINS, 32'h0000_0000);
		repeat (8) @(posedge clock_in);
		#1;
		chk("mode cleared", {28'h0, mode_control_out}, 32'h0000_0000);
		chk("awake", {31'h0, sleep_out}, 32'h0);
		$display("sleep and reset pin done");
	endtask : t_sleep

	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : give_verdict

	// Hang guard well above the 1300 or so cycles the sequence needs
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 30000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	initial begin
		nrst_in = 1'b0;
		addr_in = 8'h00;
		wdata_in = 32'h0000_0000;
		wr_in = 1'b0;
		rd_in = 1'b0;
		n_mismatch = 0;
		tests_run = 0;
		cycles = 0;
		repeat (10) @(posedge clock_in);
		nrst_in <= 1'b1;
		t_reset();
		t_narrow();
		t_command();
		t_am();
		t_sync();
		t_freq();
		t_sleep();
		give_verdict();
	end
endmodule : dds_modulator_core_test

// [verilog/ddm_core.sv]
// Modulator core: pin synchronisers, assembly registers, transfer decode, NCO and IQ path
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module ddm_core
	import ddm_pkg::*;
(
	input  wire logic        clock_in,
	input  wire logic        nrst_in,
	ddm_link_if.device       link,
	output logic [9:0]       dac_code_out,
	output logic             sleep_out,
	output logic [3:0]       mode_control_out
);

	// Quarter-free parabolic sine; a stand-in for the full ROM that keeps area small
	function automatic logic signed [9:0] ddm_sine(input logic [11:0] p);
		logic [11:0] x;
		logic [22:0] prod;
		logic [9:0]  mag;
		x    = {1'b0, p[10:0]};
		prod = 23'(x) * 23'(SINE_SPAN - x);
		mag  = (prod[22:SINE_LSB] > 12'(SINE_MAX)) ? SINE_MAX : prod[SINE_LSB +: AMP_W];
		return p[11] ? -$signed(mag) : $signed(mag);
	endfunction : ddm_sine

	// Signed 10x10 product rescaled to a 10-bit fraction
	function automatic logic [9:0] ddm_scale(input logic signed [9:0] a,
		input logic signed [9:0] b);
		logic signed [19:0] prod;
		prod = a * b;
		return prod[PROD_LSB +: AMP_W];
	endfunction : ddm_scale

	// Two-flop synchronisers for every pin; stage one is read only by stage two
	localparam int PIN_W = 2 + DATA_W + 2 + CTRL_W + 2;
	// Reset to the idle pin levels so no false strobe, clock or load edge follows reset
	localparam logic [PIN_W-1:0] PIN_IDLE = {2'h3, {(PIN_W-2){1'h0}}};
	logic [PIN_W-1:0] pin_meta;
	logic [PIN_W-1:0] pin_sync;
	wire  [PIN_W-1:0] pin_raw = {link.wr_n, link.cs_n, link.data_bus, link.serial_clk,
		link.serial_in_line, link.freq_select_input, link.load,
		link.transfer_control_inputs, link.sleep_pin, link.reset_pin};

	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pin_meta <= PIN_IDLE;
			pin_sync <= PIN_IDLE;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
		end
	end

	wire              s_wr_n     = pin_sync[PIN_W-1];
	wire              s_cs_n     = pin_sync[PIN_W-2];
	wire [DATA_W-1:0] s_data     = pin_sync[PIN_W-3 -: DATA_W];
	wire              s_sclk     = pin_sync[CTRL_W+3];
	wire              s_serial_in_line    = pin_sync[CTRL_W+2];
	wire [CTRL_W-1:0] s_ctrl     = pin_sync[CTRL_W+1:2];
	wire              s_sleep    = pin_sync[1];
	wire              s_reset    = pin_sync[0];

	logic [CR_W-1:0]  mode_control;
	logic [ACC_W-1:0] freq_word_a;
	logic [ACC_W-1:0] freq_word_b;
	logic [11:0]      phase_offset;
	logic [IQ_W-1:0]  iq_amplitude;
	logic [ACC_W-1:0] par_asm;
	logic [ACC_W-1:0] ser_asm;
	logic             wr_active;
	logic             sclk_prev;
	logic [DATA_W-1:0] data_hold;

	wire bus_width_bit            = mode_control[CR_BUS_WIDTH];
	wire sleep_bit                = mode_control[CR_SLEEP];
	wire amplitude_mod_enable_bit = mode_control[CR_AM];
	wire sync_bypass_bit          = mode_control[CR_BYPASS];

	// Extra four-stage pipeline for frequency select, load and transfer code
	logic [CTRL_W-1:0] ctrl_pipe [SYNC_STAGES];
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			for (int i = 0; i < SYNC_STAGES; i++) begin
				ctrl_pipe[i] <= '0;
			end
		end else begin
			ctrl_pipe[0] <= s_ctrl;
			for (int i = 1; i < SYNC_STAGES; i++) begin
				ctrl_pipe[i] <= ctrl_pipe[i-1];
			end
		end
	end

	// Bypass takes the synchronised pins directly, four stages sooner
	wire [CTRL_W-1:0] ctrl = sync_bypass_bit ? s_ctrl : ctrl_pipe[SYNC_STAGES-1];
	wire              freq_select_input       = ctrl[CTRL_W-1];
	wire              load_level              = ctrl[CTRL_W-2];
	wire [TC_W-1:0]   transfer_control_inputs = ctrl[TC_W-1:0];
	logic             load_prev;
	wire              load_rise = load_level && !load_prev;

	// Parallel write ends when the joint strobe goes inactive
	wire wr_now   = !s_wr_n && !s_cs_n;
	wire wr_end   = wr_active && !wr_now;
	wire sclk_up  = s_sclk && !sclk_prev;
	wire [ACC_W-1:0] par_narrow = {par_asm[ACC_W-SHIFT_NARROW-1:0],
		data_hold[SHIFT_NARROW-1:0]};
	wire [ACC_W-1:0] par_wide   = {par_asm[ACC_W-SHIFT_WIDE-1:0], data_hold};
	wire [ACC_W-1:0] next_par   = bus_width_bit ? par_wide : par_narrow;
	wire [ACC_W-1:0] next_ser   = {ser_asm[ACC_W-2:0], s_serial_in_line};

	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wr_active <= 1'b0;
			sclk_prev <= 1'b0;
			load_prev <= 1'b0;
			data_hold <= '0;
			par_asm   <= '0;
			ser_asm   <= '0;
		end else begin
			wr_active <= wr_now;
			sclk_prev <= s_sclk;
			load_prev <= load_level;
			if (wr_now) begin
				data_hold <= s_data;
			end
			// Independent paths; neither blocks the other
			if (wr_end) begin
				par_asm <= next_par;
			end
			if (sclk_up) begin
				ser_asm <= next_ser;
			end
		end
	end

	// Transfer decode
	wire              to_command = transfer_control_inputs[3:2] == TC_TOP_COMMAND;
	wire              from_ser   = transfer_control_inputs[TC_SOURCE_BIT];
	wire [1:0]        dest       = transfer_control_inputs[1:0];
	wire [ACC_W-1:0]  source     = from_ser ? ser_asm : par_asm;

	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			mode_control <= '0;
			freq_word_a  <= '0;
			freq_word_b  <= '0;
			phase_offset <= '0;
			iq_amplitude <= '0;
		end else if (s_reset) begin
			mode_control <= '0;
			freq_word_a  <= '0;
			freq_word_b  <= '0;
			phase_offset <= '0;
			iq_amplitude <= '0;
		end else if (load_rise) begin
			if (to_command) begin
				mode_control <= par_asm[CR_W-1:0];
			end else if (dest == DEST_FREQ_A) begin
				freq_word_a <= source;
			end else if (dest == DEST_FREQ_B) begin
				freq_word_b <= source;
			end else if (dest == DEST_PHASE) begin
				phase_offset <= source[PHASE_W-1:0];
			end else begin
				iq_amplitude <= source[IQ_W-1:0];
			end
		end
	end

	// Sleep from either the command bit or the pin freezes the datapath
	wire asleep = sleep_bit || s_sleep;

	logic [ACC_W-1:0] phase_acc;
	logic [PHASE_W-1:0] lut_phase;
	logic signed [9:0] sine_val;
	logic signed [9:0] cos_val;
	logic             am_stage;

	wire [ACC_W-1:0] step      = freq_select_input ? freq_word_b : freq_word_a;
	wire [ACC_W-1:0] next_acc  = phase_acc + step;
	wire [PHASE_W-1:0] offset_phase = phase_acc[ACC_W-1 -: PHASE_W] + phase_offset;
	wire [9:0] i_term  = ddm_scale(cos_val, $signed(iq_amplitude[Q_LSB-1:0]));
	wire [9:0] q_term  = ddm_scale(sine_val, $signed(iq_amplitude[IQ_W-1:Q_LSB]));
	wire [9:0] iq_sum  = i_term + q_term;
	wire [9:0] next_dac = am_stage ? iq_sum : sine_val;

	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			phase_acc    <= '0;
			lut_phase    <= '0;
			sine_val     <= '0;
			cos_val      <= '0;
			am_stage     <= 1'b0;
			dac_code_out <= '0;
		end else if (asleep) begin
			// Clocks stopped: hold phase, converter output quiet
			dac_code_out <= '0;
		end else begin
			phase_acc    <= next_acc;
			lut_phase    <= offset_phase;
			sine_val     <= ddm_sine(lut_phase);
			cos_val      <= ddm_sine(lut_phase + SINE_QUARTER);
			am_stage     <= amplitude_mod_enable_bit;
			dac_code_out <= next_dac;
		end
	end

	assign sleep_out        = asleep;
	assign mode_control_out = mode_control;

endmodule : ddm_core

// [verilog/ddm_host.sv]
// Loading controller: turns software commands into parallel, serial and load pin sequences
`timescale 1ns/10ps
module ddm_host
	import ddm_pkg::*;
(
	input  wire logic        clock_in,
	input  wire logic        nrst_in,
	input  wire logic [7:0]  addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic [31:0]      rdata_out,
	output logic             busy_out,
	ddm_link_if.host         link
);

	typedef enum {ST_IDLE, ST_PAR_ACT, ST_PAR_REC, ST_SER_LOW, ST_SER_HIGH,
		ST_LD_SETUP, ST_LD_HIGH, ST_LD_HOLD} ddm_state_type;

	ddm_state_type state;
	logic [7:0]  phase_cnt;
	logic [5:0]  bit_cnt;
	logic [31:0] ser_shift;
	logic [2:0]  pins;

	// Every pin phase lasts several core clocks so the far synchronisers see each level
	wire phase_done = phase_cnt == 8'(HOST_PHASE_CYCLES - 1);
	wire idle       = state == ST_IDLE;
	wire go_par     = wr_in && idle && addr_in == ADDR_PAR;
	wire go_ser     = wr_in && idle && addr_in == ADDR_SER;
	wire go_load    = wr_in && idle && addr_in == ADDR_LOAD;
	wire set_pins   = wr_in && addr_in == ADDR_PINS;
	wire [31:0] status_word = {31'h0000_0000, !idle};
	wire [31:0] pins_word   = {29'h0000_0000, pins};
	wire [31:0] read_mux    = (addr_in == ADDR_STATUS) ? status_word :
		(addr_in == ADDR_PINS) ? pins_word : 32'h0000_0000;

	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state     <= ST_IDLE;
			phase_cnt <= '0;
			bit_cnt   <= '0;
			ser_shift <= '0;
			pins      <= '0;
			rdata_out <= '0;
			link.wr_n <= 1'b1;
			link.cs_n <= 1'b1;
			link.data_bus   <= '0;
			link.serial_clk <= 1'b0;
			link.serial_in_line <= 1'b0;
			link.load <= 1'b0;
			link.transfer_control_inputs <= '0;
		end else begin
			rdata_out <= rd_in ? read_mux : 32'h0000_0000;
			phase_cnt <= (idle || phase_done) ? 8'h00 : phase_cnt + 8'h01;
			if (set_pins) begin
				pins <= wdata_in[2:0];
			end
			case (state)
				ST_IDLE: begin
					if (go_par) begin
						link.data_bus <= wdata_in[DATA_W-1:0];
						link.wr_n     <= 1'b0;
						link.cs_n     <= 1'b0;
						state         <= ST_PAR_ACT;
					end else if (go_ser) begin
						ser_shift <= {wdata_in[30:0], 1'b0};
						link.serial_in_line <= wdata_in[31];
						bit_cnt   <= 6'(SER_BITS - 1);
						state     <= ST_SER_LOW;
					end else if (go_load) begin
						link.transfer_control_inputs <= wdata_in[TC_W-1:0];
						state     <= ST_LD_SETUP;
					end
				end
				ST_PAR_ACT: begin
					if (phase_done) begin
						link.wr_n <= 1'b1;
						link.cs_n <= 1'b1;
						state     <= ST_PAR_REC;
					end
				end
				ST_PAR_REC: begin
					if (phase_done) begin
						state <= ST_IDLE;
					end
				end
				ST_SER_LOW: begin
					if (phase_done) begin
						link.serial_clk <= 1'b1;
						state <= ST_SER_HIGH;
					end
				end
				ST_SER_HIGH: begin
					if (phase_done) begin
						link.serial_clk <= 1'b0;
						if (bit_cnt == 6'h00) begin
							state <= ST_IDLE;
						end else begin
							link.serial_in_line <= ser_shift[31];
							ser_shift <= {ser_shift[30:0], 1'b0};
							bit_cnt   <= bit_cnt - 6'h01;
							state     <= ST_SER_LOW;
						end
					end
				end
				ST_LD_SETUP: begin
					if (phase_done) begin
						link.load <= 1'b1;
						state     <= ST_LD_HIGH;
					end
				end
				ST_LD_HIGH: begin
					if (phase_done) begin
						link.load <= 1'b0;
						state     <= ST_LD_HOLD;
					end
				end
				default: begin
					// Code stays put past the falling load edge
					if (phase_done) begin
						state <= ST_IDLE;
					end
				end
			endcase
		end
	end

	assign busy_out                 = !idle;
	assign link.freq_select_input   = pins[PIN_FSEL];
	assign link.sleep_pin           = pins[PIN_SLEEP];
	assign link.reset_pin           = pins[PIN_RESET];

endmodule : ddm_host
